// file: radio_seq_cfg.svh
// Constants of the radio-side message sequencer.
`ifndef RADIO_SEQ_CFG_SVH
`define RADIO_SEQ_CFG_SVH
`define CLK_HZ 25000000
`define TICK_MS 100
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define QUERY_MS 1600
`define STARTUP_MS 50000
`define TIME_MS 20000
`define SIGNAL_MS 60000
`define QUERY_TICKS (`QUERY_MS / `TICK_MS)
`define STARTUP_TICKS (`STARTUP_MS / `TICK_MS)
`define TIME_TICKS (`TIME_MS / `TICK_MS)
`define SIGNAL_TICKS (`SIGNAL_MS / `TICK_MS)
`define CODE_INIT_QUERY 8'h1C
`define CODE_DEV_INFO 8'h83
`define CODE_POWER 8'h82
`define CODE_JOIN_QUERY 8'h0D
`define CODE_JOIN_NOTICE 8'h0A
`define CODE_TIME 8'h0B
`define CODE_SIGNAL 8'h0C
`define CODE_REGEN_END 8'h8D
`define CODE_REGEN_ACK 8'h8E
`endif

// file: radio_seq_pkg.sv
// Types of the radio-side message sequencer.
`default_nettype none
package radio_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STARTUP = 3'b010,
    ST_NORMAL = 3'b100
  } seq_state_t;
endpackage
`default_nettype wire

// file: tick_if.sv
// Tick carrier shared between the sequencer and its period timers.
`default_nettype none
interface tick_if;
  logic tick;
  logic srst;
  modport src (output tick, output srst);
  modport dst (input tick, input srst);
endinterface
`default_nettype wire

// file: period_timer.sv
// Period timer counting ticks; fires and restarts on expiry; a restart request clears it without firing.
`default_nettype none
module period_timer #(
  parameter int unsigned TICKS = 16
) (
  input wire logic clk,
  tick_if.dst tk,
  input wire logic run,
  input wire logic restart,
  output logic fire
);
  logic [15:0] count;

  always_ff @(posedge clk) begin
    if (tk.srst || !run || restart) begin
      count <= 16'h0000;
    end else if (tk.tick) begin
      count <= (count == 16'(TICKS - 1)) ? 16'h0000 : count + 16'h0001;
    end
  end

  assign fire = run && !restart && tk.tick && (count == 16'(TICKS - 1));
endmodule // period_timer
`default_nettype wire

// file: radio_seq.sv
// Radio-side start-up and periodic message sequencer.
`default_nettype none
`include "radio_seq_cfg.svh"
module radio_seq
  import radio_seq_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_CODE,
  input wire logic JOINED,
  input wire logic TX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_CODE,
  output logic [7:0] TX_DATA,
  output logic NORMAL_MODE,
  output logic LOW_BATTERY,
  output logic DEV_INFO_SEEN
);
  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  seq_state_t state;
  logic [23:0] div;
  logic power_seen;
  logic joined_q;
  logic ack_pend;
  logic query_pend, time_pend, sig_pend, join_pend;
  logic query_fire, time_fire, sig_fire, startup_fire;
  logic [7:0] next_code;
  logic [7:0] next_data;
  logic next_take;
  tick_if tk ();

  // One tick every 100 ms keeps each period counter small.
  // The price is that every interval is exact only to one tick.
  always_ff @(posedge CLK) begin
    if (SRST || div == 24'(`TICK_CYCLES - 1)) begin
      div <= 24'h000000;
    end else begin
      div <= div + 24'h000001;
    end
  end
  assign tk.tick = (div == 24'(`TICK_CYCLES - 1));
  assign tk.srst = SRST;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  period_timer #(.TICKS(`QUERY_TICKS)) u_query (.clk(CLK), .tk(tk),
    .run(state == ST_STARTUP), .restart(1'b0), .fire(query_fire));
  period_timer #(.TICKS(`STARTUP_TICKS)) u_start (.clk(CLK), .tk(tk),
    .run(state == ST_STARTUP), .restart(1'b0), .fire(startup_fire));
  period_timer #(.TICKS(`TIME_TICKS)) u_time (.clk(CLK), .tk(tk),
    .run(state == ST_NORMAL), .restart(1'b0), .fire(time_fire));
  period_timer #(.TICKS(`SIGNAL_TICKS)) u_sig (.clk(CLK), .tk(tk),
    .run(state == ST_NORMAL), .restart(1'b0), .fire(sig_fire));

  // ----------------------------------------
  // Mode sequencing
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= ST_STARTUP;
        ST_STARTUP: if (startup_fire) state <= ST_NORMAL;
        ST_NORMAL: state <= ST_NORMAL;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      power_seen <= 1'b0;
      DEV_INFO_SEEN <= 1'b0;
    end else if (RX_VALID && state == ST_STARTUP) begin
      if (RX_CODE == `CODE_POWER) power_seen <= 1'b1;
      if (RX_CODE == `CODE_DEV_INFO) DEV_INFO_SEEN <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      NORMAL_MODE <= 1'b0;
      LOW_BATTERY <= 1'b0;
    end else if (state == ST_STARTUP && startup_fire) begin
      NORMAL_MODE <= 1'b1;
      LOW_BATTERY <= !power_seen && !DEV_INFO_SEEN;
    end
  end

  // ----------------------------------------
  // Pending messages
  // ----------------------------------------
  // A pending flag set in the cycle it is sent stays set, so no event is lost.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      query_pend <= 1'b0;
      time_pend <= 1'b0;
      sig_pend <= 1'b0;
      join_pend <= 1'b0;
      ack_pend <= 1'b0;
      joined_q <= 1'b0;
    end else begin
      joined_q <= (state == ST_NORMAL) ? JOINED : 1'b0;
      if ((state == ST_IDLE) || query_fire) begin
        query_pend <= 1'b1;
      end else if (next_take && next_code == `CODE_INIT_QUERY) begin
        query_pend <= 1'b0;
      end
      if (time_fire) begin
        time_pend <= 1'b1;
      end else if (next_take && next_code == `CODE_TIME) begin
        time_pend <= 1'b0;
      end
      if (sig_fire) begin
        sig_pend <= 1'b1;
      end else if (next_take && next_code == `CODE_SIGNAL) begin
        sig_pend <= 1'b0;
      end
      if (state == ST_NORMAL && JOINED != joined_q) begin
        join_pend <= 1'b1;
      end else if (next_take && next_code == `CODE_JOIN_NOTICE) begin
        join_pend <= 1'b0;
      end
      if (RX_VALID && RX_CODE == `CODE_REGEN_END) begin
        ack_pend <= 1'b1;
      end else if (next_take && next_code == `CODE_REGEN_ACK) begin
        ack_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmit arbitration
  // ----------------------------------------
  always_comb begin
    next_code = 8'h00;
    next_data = 8'h00;
    if (ack_pend) begin
      next_code = `CODE_REGEN_ACK;
    end else if (join_pend) begin
      next_code = `CODE_JOIN_NOTICE;
      next_data = {7'h00, joined_q};
    end else if (query_pend) begin
      next_code = `CODE_INIT_QUERY;
    end else if (time_pend) begin
      next_code = `CODE_TIME;
    end else if (sig_pend) begin
      next_code = `CODE_SIGNAL;
    end
    next_take = (!TX_VALID || TX_READY) && (next_code != 8'h00);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      TX_VALID <= 1'b0;
      TX_CODE <= 8'h00;
      TX_DATA <= 8'h00;
    end else if (next_take) begin
      TX_VALID <= 1'b1;
      TX_CODE <= next_code;
      TX_DATA <= next_data;
    end else if (TX_READY) begin
      TX_VALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_first_query: assert property (@(posedge CLK) disable iff (SRST)
    $rose(state == ST_STARTUP) |-> ##[0:3] (TX_VALID && TX_CODE == `CODE_INIT_QUERY))
    else $error("Start-up query not sent.");
  chk_ack_regen: assert property (@(posedge CLK) disable iff (SRST)
    (RX_VALID && RX_CODE == `CODE_REGEN_END && !TX_VALID) |-> ##[1:3]
    (TX_VALID && TX_CODE == `CODE_REGEN_ACK))
    else $error("Regeneration end not acknowledged.");
  chk_normal_late: assert property (@(posedge CLK) disable iff (SRST)
    (state == ST_STARTUP) |-> !NORMAL_MODE)
    else $error("Normal mode before window end.");
  chk_no_query_normal: assert property (@(posedge CLK) disable iff (SRST)
    (state == ST_NORMAL && $past(state) == ST_NORMAL) |-> !query_fire)
    else $error("Query timer running in normal mode.");
  chk_low_batt: assert property (@(posedge CLK) disable iff (SRST)
    $rose(NORMAL_MODE) |-> (LOW_BATTERY == (!$past(power_seen) && !$past(DEV_INFO_SEEN))))
    else $error("Low battery state wrong.");
  chk_time_norm: assert property (@(posedge CLK) disable iff (SRST)
    time_fire |-> NORMAL_MODE)
    else $error("Time sent outside normal mode.");
  chk_sig_norm: assert property (@(posedge CLK) disable iff (SRST)
    sig_fire |-> NORMAL_MODE)
    else $error("Signal report outside normal mode.");
  chk_join_data: assert property (@(posedge CLK) disable iff (SRST)
    (TX_VALID && TX_CODE == `CODE_JOIN_NOTICE) |-> (TX_DATA[7:1] == 7'h00))
    else $error("Join notice data malformed.");
  chk_tick_rate: assert property (@(posedge CLK) disable iff (SRST)
    tk.tick |=> !tk.tick)
    else $error("Tick repeated.");
  chk_tx_hold: assert property (@(posedge CLK) disable iff (SRST)
    (TX_VALID && !TX_READY) |=>
    (TX_VALID && $stable(TX_CODE) && $stable(TX_DATA)))
    else $error("Transmit word changed before it was taken.");
  chk_idle_query: assert property (@(posedge CLK) disable iff (SRST)
    (state == ST_IDLE) |=> query_pend)
    else $error("Start-up query not queued.");
  chk_query_repeat: assert property (@(posedge CLK) disable iff (SRST)
    query_fire |=> query_pend)
    else $error("Repeated query not queued.");
  chk_ack_data: assert property (@(posedge CLK) disable iff (SRST)
    (TX_VALID && TX_CODE == `CODE_REGEN_ACK) |-> (TX_DATA == 8'h00))
    else $error("Acknowledge carries data.");
  chk_mode_hold: assert property (@(posedge CLK) disable iff (SRST)
    NORMAL_MODE |=> NORMAL_MODE)
    else $error("Normal mode left without reset.");
  chk_info_hold: assert property (@(posedge CLK) disable iff (SRST)
    DEV_INFO_SEEN |=> DEV_INFO_SEEN)
    else $error("Device information flag lost.");
  cov_normal: cover property (@(posedge CLK) $rose(NORMAL_MODE));
  cov_ack: cover property (@(posedge CLK) TX_VALID && TX_CODE == `CODE_REGEN_ACK);
  cov_join: cover property (@(posedge CLK) TX_VALID && TX_CODE == `CODE_JOIN_NOTICE);
  cov_query: cover property (@(posedge CLK) TX_VALID && TX_READY && TX_CODE == `CODE_INIT_QUERY);
endmodule // radio_seq
`default_nettype wire

// file: sensor_model.sv
// Sensor board model that sends codes to the radio and sinks its messages.
`default_nettype none
module sensor_model (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] code,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_code,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_code,
  output logic tx_ready,
  output logic got,
  output logic [7:0] got_code,
  output logic [7:0] got_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_valid = 1'b0;
    rx_code = 8'h00;
    tx_ready = 1'b0;
    got = 1'b0;
    got_code = 8'h00;
    got_data = 8'h00;
  end
  // The code line flips between messages so that a stale value is never read as new.
  always @(negedge clk) begin
    rx_valid <= send;
    rx_code <= send ? code : ~rx_code;
    tx_ready <= !stall;
  end
  always @(posedge clk) begin
    got <= tx_valid && tx_ready;
    if (tx_valid && tx_ready) begin
      got_code <= tx_code;
      got_data <= tx_data;
    end
  end
endmodule // sensor_model
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the radio message sequencer.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic JOINED = 1'b0;
  logic send = 1'b0;
  logic stall = 1'b1;
  logic [7:0] code = 8'h00;
  wire RX_VALID, TX_READY, TX_VALID, NORMAL_MODE, LOW_BATTERY, DEV_INFO_SEEN, got;
  wire [7:0] RX_CODE, TX_CODE, TX_DATA, got_code, got_data;
  int err_total = 0;
  int checks_done = 0;
  always #20 CLK = ~CLK;
  radio_seq i_dut (.CLK(CLK), .SRST(SRST), .RX_VALID(RX_VALID), .RX_CODE(RX_CODE),
    .JOINED(JOINED), .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_CODE(TX_CODE),
    .TX_DATA(TX_DATA), .NORMAL_MODE(NORMAL_MODE), .LOW_BATTERY(LOW_BATTERY),
    .DEV_INFO_SEEN(DEV_INFO_SEEN));
  sensor_model i_board (.clk(CLK), .send(send), .code(code), .stall(stall),
    .tx_valid(TX_VALID), .tx_code(TX_CODE), .tx_data(TX_DATA), .rx_valid(RX_VALID),
    .rx_code(RX_CODE), .tx_ready(TX_READY), .got(got), .got_code(got_code),
    .got_data(got_data));
  task finish_test;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task check(input logic [7:0] exp, input logic [7:0] act);
    checks_done++;
    if (exp !== act) begin
      err_total++;
      $display("unexpected at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask
  // Bounded wait for the board to take one word; a hang ends the run.
  task wait_got;
    int n;
    n = 0;
    while (got !== 1'b1 && n < 200) begin
      @(negedge CLK);
      n++;
    end
    if (got !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: expected 01, got 00", $time);
      finish_test();
    end
  endtask
  task do_reset;
    @(negedge CLK);
    SRST <= 1'b1;
    repeat (8) @(negedge CLK);
    SRST <= 1'b0;
  endtask
  task send_code(input logic [7:0] c);
    @(negedge CLK);
    send <= 1'b1;
    code <= c;
    @(negedge CLK);
    send <= 1'b0;
  endtask
  task test_startup;
    stall <= 1'b1;
    do_reset();
    check(8'h00, {5'h00, NORMAL_MODE, LOW_BATTERY, DEV_INFO_SEEN});
    repeat (4) @(negedge CLK);
    check(8'h01, {7'h00, TX_VALID});
    check(8'h1C, TX_CODE);
    check(8'h00, TX_DATA);
    // A stalled sink must see the same word until it takes it.
    repeat (20) @(negedge CLK);
    check(8'h01, {7'h00, TX_VALID});
    check(8'h1C, TX_CODE);
    stall <= 1'b0;
    wait_got();
    check(8'h1C, got_code);
    $display("test startup done");
  endtask
  task test_notices;
    send_code(8'h82);
    repeat (3) @(negedge CLK);
    check(8'h00, {7'h00, LOW_BATTERY});
    check(8'h00, {7'h00, DEV_INFO_SEEN});
    send_code(8'h83);
    repeat (3) @(negedge CLK);
    check(8'h01, {7'h00, DEV_INFO_SEEN});
    check(8'h00, {7'h00, NORMAL_MODE});
    $display("test notices done");
  endtask
  task test_regen;
    send_code(8'h8D);
    wait_got();
    check(8'h8E, got_code);
    check(8'h00, got_data);
    $display("test regen done");
  endtask
  // Join changes during start-up must not produce a join notice.
  task test_join;
    int n;
    n = 0;
    @(negedge CLK);
    JOINED <= 1'b1;
    repeat (50) begin
      @(negedge CLK);
      n += (got === 1'b1);
    end
    JOINED <= 1'b0;
    check(8'h00, n[7:0]);
    $display("test join done");
  endtask
  // Alarms and contract requests get no answer; only the regeneration end is acknowledged.
  task test_alarms;
    int n;
    n = 0;
    send_code(8'h1E);
    send_code(8'h15);
    send_code(8'h1E);
    repeat (8) begin
      @(negedge CLK);
      n += (got === 1'b1);
    end
    check(8'h00, n[7:0]);
    send_code(8'h8D);
    repeat (8) begin
      @(negedge CLK);
      if (got === 1'b1) begin
        n++;
        check(8'h8E, got_code);
      end
    end
    check(8'h01, n[7:0]);
    $display("test alarms done");
  endtask
  task test_restart;
    stall <= 1'b1;
    do_reset();
    check(8'h00, {7'h00, DEV_INFO_SEEN});
    repeat (4) @(negedge CLK);
    check(8'h01, {7'h00, TX_VALID});
    check(8'h1C, TX_CODE);
    stall <= 1'b0;
    wait_got();
    check(8'h1C, got_code);
    $display("test restart done");
  endtask
  initial begin
    test_startup();
    test_notices();
    test_regen();
    test_alarms();
    test_join();
    test_restart();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
